// ==== verification/mrm_core_properties.sv ====
// Purpose: Port-level timing checks for the mode and map block
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to every instance of the core
`timescale 1ns/1ps
module mrm_core_properties
(
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic [15:0] cpu_addr_in,
   input wire logic cpu_valid_in,
   input wire logic cpu_idle_in,
   input wire logic dbg_req_in,
   input wire logic dbg_grant_out,
   input wire mrm_pkg::mrm_sel_t sel_out,
   input wire logic ext_busy_out,
   input wire logic cpu_halt_out,
   input wire logic skip_vector_out,
   input wire logic debug_active_out,
   input wire mrm_pkg::mrm_pins_t pins_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   chk_grant_cause: assert property (
      dbg_grant_out |-> dbg_req_in && cpu_idle_in && !cpu_valid_in)
      else $error("debug grant without an idle bus");
   chk_sel_idle: assert property (
      !cpu_valid_in |-> sel_out == mrm_pkg::MRM_SEL_NONE)
      else $error("decode active without a request");
   chk_dbg_rom: assert property (
      debug_active_out && cpu_valid_in && cpu_addr_in[15:8] == 8'hff
      |-> sel_out == mrm_pkg::MRM_SEL_DBG)
      else $error("debug rom lost its top page");
   chk_split_len: assert property (
      $rose(ext_busy_out) |-> ##1 ext_busy_out ##1 !ext_busy_out)
      else $error("split transfer not two byte cycles");
   chk_split_cause: assert property (
      $rose(ext_busy_out)
      |-> $past(cpu_valid_in) && $past(sel_out) == mrm_pkg::MRM_SEL_EXT)
      else $error("external cycle without external decode");
   chk_rdata_quiet: assert property (
      !$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
      else $error("read data outside its cycle");
   chk_pullup_set: assert property (
      pins_out.e_pullup == 8'h03 && !pins_out.ab_pullup)
      else $error("pullup setting wrong");
   chk_sc_nobus: assert property (
      skip_vector_out |-> pins_out.a_oe == 8'h00 && pins_out.b_oe == 8'h00
      && !ext_busy_out)
      else $error("bus driven in special single chip");
   chk_periph_quiet: assert property (
      cpu_halt_out && $past(cpu_halt_out) |-> !dbg_grant_out)
      else $error("debug granted in peripheral mode");
endmodule

bind mrm_core mrm_core_properties chk
(
   .clk_in(clk_in),
   .rst_b_in(rst_b_in),
   .reg_rd_in(reg_rd_in),
   .reg_rdata_out(reg_rdata_out),
   .cpu_addr_in(cpu_addr_in),
   .cpu_valid_in(cpu_valid_in),
   .cpu_idle_in(cpu_idle_in),
   .dbg_req_in(dbg_req_in),
   .dbg_grant_out(dbg_grant_out),
   .sel_out(sel_out),
   .ext_busy_out(ext_busy_out),
   .cpu_halt_out(cpu_halt_out),
   .skip_vector_out(skip_vector_out),
   .debug_active_out(debug_active_out),
   .pins_out(pins_out)
);

// ==== verification/mrm_ext_mem.sv ====
// Purpose: External memory on the multiplexed port A bus
// Assumes: Only write transfers reach it here
// Notes: Keeps the last two bytes and a byte cycle count
`timescale 1ns/1ps
module mrm_ext_mem
(
   input wire logic clk_in,
   input wire logic busy_in,
   input wire mrm_pkg::mrm_pins_t pins_in,
   output logic [3:0] cnt_out,
   output logic [15:0] data_out
);
   initial
   begin
      cnt_out = 4'h0;
      data_out = 16'h0000;
   end
   // One byte per busy cycle, high byte first
   always @(posedge clk_in)
   begin
      if (busy_in)
      begin
         cnt_out <= cnt_out + 4'h1;
         data_out <= {data_out[7:0], pins_in.a_out};
      end
   end
endmodule

// ==== verification/tb_mrm_core.sv ====
// Purpose: Self-checking bench for the mode and map block
// Assumes: Straps steady through each reset
// Notes: Mode rows first, then writes, decode and debug cases
`timescale 1ns/1ps
module tb_mrm_core;
   typedef struct packed {
      logic [2:0] strap;
      logic [7:0] mode;
      logic skip;
      logic halt;
   } mrm_row_t;
   mrm_row_t rows [8] = '{'{3'h0, 8'h19, 1'b1, 1'b0},
      '{3'h1, 8'h39, 1'b0, 1'b0}, '{3'h2, 8'h00, 1'b0, 1'b1},
      '{3'h3, 8'h79, 1'b0, 1'b0}, '{3'h4, 8'h90, 1'b0, 1'b0},
      '{3'h5, 8'hb0, 1'b0, 1'b0}, '{3'h6, 8'h00, 1'b0, 1'b1},
      '{3'h7, 8'hf0, 1'b0, 1'b0}};
   logic clk_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic [2:0] strap = 3'h4;
   logic [15:0] reg_addr_in = 16'h0000;
   logic [7:0] reg_wdata_in = 8'h00;
   logic reg_wr_in = 1'b0;
   logic reg_rd_in = 1'b0;
   logic [15:0] cpu_addr_in = 16'h0000;
   logic cpu_valid_in = 1'b0;
   logic cpu_idle_in = 1'b0;
   // Kept low in peripheral mode to avoid bus clashes
   logic dbg_req_in = 1'b0;
   logic [3:0] ctl = 4'h0;
   logic [7:0] reg_rdata_out;
   logic dbg_grant_out, ext_busy_out, cpu_halt_out;
   logic skip_vector_out, debug_active_out;
   mrm_pkg::mrm_sel_t sel_out;
   mrm_pkg::mrm_pins_t pins_out;
   logic [3:0] ext_cnt;
   logic [15:0] ext_data;
   logic [7:0] d;
   int bad_count = 0;
   int comparisons = 0;

   always #5 clk_in = ~clk_in;

   mrm_core dut
   (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .dbg_pin_in(strap[2]),
      .strap_high_in(strap[1]),
      .strap_low_in(strap[0]),
      .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in),
      .reg_wr_in(reg_wr_in),
      .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out),
      .cpu_addr_in(cpu_addr_in),
      .cpu_valid_in(cpu_valid_in),
      .cpu_we_in(1'b1),
      .cpu_wdata_in(16'ha55a),
      .cpu_idle_in(cpu_idle_in),
      .dbg_enable_cmd_in(ctl[0]),
      .dbg_serial_act_in(ctl[1]),
      .background_enter_instruction_exec_in(ctl[2]),
      .dbg_exit_in(ctl[3]),
      .dbg_req_in(dbg_req_in),
      .dbg_grant_out(dbg_grant_out),
      .sel_out(sel_out),
      .ext_busy_out(ext_busy_out),
      .cpu_halt_out(cpu_halt_out),
      .skip_vector_out(skip_vector_out),
      .debug_active_out(debug_active_out),
      .pins_out(pins_out)
   );

   mrm_ext_mem ext
   (
      .clk_in(clk_in),
      .busy_in(ext_busy_out),
      .pins_in(pins_out),
      .cnt_out(ext_cnt),
      .data_out(ext_data)
   );

   task automatic chk(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Synchronizer needs three edges with straps stable
   task automatic do_reset(input logic [2:0] s);
      @(posedge clk_in);
      rst_b_in <= 1'b0;
      strap <= s;
      repeat (4) @(posedge clk_in);
      rst_b_in <= 1'b1;
      repeat (3) @(posedge clk_in);
   endtask

   task automatic wr_reg(input logic [15:0] a, input logic [7:0] v);
      @(posedge clk_in);
      reg_wr_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= v;
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
   endtask

   task automatic rd_reg(input logic [15:0] a, output logic [7:0] v);
      @(posedge clk_in);
      reg_rd_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge clk_in);
      reg_rd_in <= 1'b0;
      #1;
      v = reg_rdata_out;
   endtask

   task automatic decode(input logic [15:0] a, input mrm_pkg::mrm_sel_t e);
      @(posedge clk_in);
      cpu_addr_in <= a;
      cpu_valid_in <= 1'b1;
      #1;
      chk("sel", 8'(sel_out), 8'(e));
      @(posedge clk_in);
      cpu_valid_in <= 1'b0;
   endtask

   task automatic pulse(input int k);
      @(posedge clk_in);
      ctl[k] <= 1'b1;
      @(posedge clk_in);
      ctl[k] <= 1'b0;
      repeat (3) @(posedge clk_in);
   endtask

   initial
   begin
      #50000;
      bad_count++;
      end_of_test();
   end

   initial
   begin
      for (int i = 0; i < 8; i++)
      begin
         do_reset(rows[i].strap);
         rd_reg(mrm_pkg::MODE_OFS, d);
         chk("mode", d, rows[i].mode);
         chk("skip", 8'(skip_vector_out), 8'(rows[i].skip));
         chk("halt", 8'(cpu_halt_out), 8'(rows[i].halt));
         chk("dbg", 8'(debug_active_out), 8'(rows[i].strap == 0));
         chk("pullup", pins_out.e_pullup, 8'h03);
         if (rows[i].strap[1:0] == 2'h0)
            chk("a_oe", pins_out.a_oe, 8'h00);
         if (rows[i].strap == 3'h3)
            chk("busctl", 8'(pins_out.e_bus_ctl), 8'h01);
         $display("mode row %0d done", i);
      end
      do_reset(3'h3);
      wr_reg(mrm_pkg::MODE_OFS, 8'h7b);
      wr_reg(mrm_pkg::MODE_OFS, 8'h59);
      rd_reg(mrm_pkg::MODE_OFS, d);
      chk("refuse", d, 8'h79);
      rd_reg(16'h0020, d);
      chk("unmapped", d, 8'h00);
      $display("refusal test done");
      do_reset(3'h1);
      decode(16'h4000, mrm_pkg::MRM_SEL_EXT);
      decode(16'h0800, mrm_pkg::MRM_SEL_RAM);
      repeat (3) @(posedge clk_in);
      chk("ext_cnt", 8'(ext_cnt), 8'h02);
      chk("ext_hi", ext_data[15:8], 8'ha5);
      chk("ext_lo", ext_data[7:0], 8'h5a);
      wr_reg(mrm_pkg::MODE_OFS, 8'hb9);
      rd_reg(mrm_pkg::MODE_OFS, d);
      chk("sel_first", d, 8'h39);
      wr_reg(mrm_pkg::MODE_OFS, 8'hb9);
      wr_reg(mrm_pkg::MODE_OFS, 8'hf9);
      wr_reg(mrm_pkg::MODE_OFS, 8'hb9);
      rd_reg(mrm_pkg::MODE_OFS, d);
      chk("sel_once", d, 8'hf9);
      $display("split and select test done");
      do_reset(3'h7);
      decode(16'h0000, mrm_pkg::MRM_SEL_REG);
      decode(16'h0d00, mrm_pkg::MRM_SEL_EE);
      wr_reg(mrm_pkg::RELOC_RAM_OFS, 8'h00);
      decode(16'h0200, mrm_pkg::MRM_SEL_RAM);
      decode(16'h0000, mrm_pkg::MRM_SEL_REG);
      wr_reg(mrm_pkg::RELOC_RAM_OFS, 8'h08);
      repeat (2) @(posedge clk_in);
      decode(16'h0800, mrm_pkg::MRM_SEL_EXT);
      @(posedge clk_in);
      cpu_valid_in <= 1'b1;
      #1;
      chk("wide_a", pins_out.a_out, 8'ha5);
      chk("wide_b", pins_out.b_out, 8'h5a);
      @(posedge clk_in);
      cpu_valid_in <= 1'b0;
      $display("relocation test done");
      do_reset(3'h4);
      decode(16'hff00, mrm_pkg::MRM_SEL_FLASH);
      pulse(2);
      chk("dbg_off", 8'(debug_active_out), 8'h00);
      pulse(0);
      pulse(2);
      chk("dbg_on", 8'(debug_active_out), 8'h01);
      decode(16'hff06, mrm_pkg::MRM_SEL_DBG);
      decode(16'h8000, mrm_pkg::MRM_SEL_FLASH);
      @(posedge clk_in);
      dbg_req_in <= 1'b1;
      cpu_idle_in <= 1'b1;
      #1;
      chk("grant", 8'(dbg_grant_out), 8'h01);
      decode(16'hfff0, mrm_pkg::MRM_SEL_DBG);
      dbg_req_in <= 1'b0;
      pulse(3);
      chk("dbg_exit", 8'(debug_active_out), 8'h00);
      $display("debug test done");
      end_of_test();
   end
endmodule

// ==== verilog/mrm_core.sv ====
// Purpose: Operating-mode control and internal resource decode
// Assumes: Straps steady around reset release, debug commands pre-decoded
// Notes: Functional notes
`timescale 1ns/1ps
module mrm_core
(
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic dbg_pin_in,
   input wire logic strap_high_in,
   input wire logic strap_low_in,
   input wire logic [15:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   input wire logic [15:0] cpu_addr_in,
   input wire logic cpu_valid_in,
   input wire logic cpu_we_in,
   input wire logic [15:0] cpu_wdata_in,
   input wire logic cpu_idle_in,
   input wire logic dbg_enable_cmd_in,
   input wire logic dbg_serial_act_in,
   input wire logic background_enter_instruction_exec_in,
   input wire logic dbg_exit_in,
   input wire logic dbg_req_in,
   output logic dbg_grant_out,
   output mrm_pkg::mrm_sel_t sel_out,
   output logic ext_busy_out,
   output logic cpu_halt_out,
   output logic skip_vector_out,
   output logic debug_active_out,
   output mrm_pkg::mrm_pins_t pins_out
);
   mrm_pkg::mrm_state_t s_q;
   mrm_pkg::mrm_state_t s_d;
   mrm_pkg::mrm_mode_t mode_now;
   logic special;
   logic expanded;
   logic narrow;
   logic periph;
   logic strap_live;
   logic reset_seen_q;

   function automatic logic in_win(input logic [15:0] a,
                                   input logic [15:0] base,
                                   input logic [15:0] size);
      logic [15:0] off;
      off = a - base;
      in_win = off < size;
   endfunction

   function automatic logic is_periph(input logic [2:0] m);
      is_periph = m == mrm_pkg::MRM_PERIPH || m == mrm_pkg::MRM_RESERVED;
   endfunction

   function automatic mrm_pkg::mrm_sel_t decode(input logic [15:0] a,
                                                 input mrm_pkg::mrm_state_t st,
                                                 input logic exp_m);
      logic [15:0] flash_lo;
      flash_lo = exp_m ? 16'h0000 : mrm_pkg::FLASH_LO_SC;
      if (st.dbg_act && a >= mrm_pkg::DBG_ROM_LO)
         decode = mrm_pkg::MRM_SEL_DBG;
      else if (in_win(a, st.reg_base, mrm_pkg::REG_SIZE))
         decode = mrm_pkg::MRM_SEL_REG;
      else if (in_win(a, st.ram_base, mrm_pkg::RAM_SIZE))
         decode = mrm_pkg::MRM_SEL_RAM;
      else if (in_win(a, st.ee_base, mrm_pkg::EE_SIZE))
         decode = mrm_pkg::MRM_SEL_EE;
      else if (!exp_m && a >= flash_lo)
         decode = mrm_pkg::MRM_SEL_FLASH;
      else if (exp_m)
         decode = mrm_pkg::MRM_SEL_EXT;
      else
         decode = mrm_pkg::MRM_SEL_NONE;
   endfunction

   assign mode_now = mrm_pkg::mrm_mode_t'({s_q.mode[mrm_pkg::B_SEL],
      s_q.mode[mrm_pkg::B_MHI], s_q.mode[mrm_pkg::B_MLO]});
   assign special = !s_q.mode[mrm_pkg::B_SEL];
   assign periph = is_periph(mode_now);
   assign expanded = s_q.mode[mrm_pkg::B_MLO] && !periph;
   assign narrow = expanded && !s_q.mode[mrm_pkg::B_MHI];

   always_comb
   begin
      logic [7:0] w;
      logic [2:0] cand;
      logic [2:0] code;
      logic map_hit;
      w = reg_wdata_in;
      cand = 3'h0;
      code = 3'h0;
      map_hit = 1'b0;
      s_d = s_q;
      // Pin synchronisers, a change counts when stages two and three agree
      s_d.sync_a = {s_q.sync_a[1:0], dbg_pin_in};
      s_d.sync_b = {s_q.sync_b[1:0], strap_high_in};
      s_d.sync_c = {s_q.sync_c[1:0], strap_low_in};
      s_d.cmd_q = 1'b0;
      if (!reset_seen_q)
      begin
         // First cycle after reset release: latch straps
         code = {s_q.sync_a[2], s_q.sync_b[2], s_q.sync_c[2]};
         if (code == mrm_pkg::MRM_RESERVED)
            code = mrm_pkg::MRM_PERIPH;
         s_d.mode = 8'h00;
         s_d.mode[mrm_pkg::B_SEL] = code[2];
         s_d.mode[mrm_pkg::B_MHI] = code[1];
         s_d.mode[mrm_pkg::B_MLO] = code[0];
         s_d.mode[mrm_pkg::B_E_CLOCK_STRETCH_ENABLE] = 1'b1;
         s_d.mode[mrm_pkg::B_INTERNAL_ACCESS_VISIBLE] = !code[2];
         s_d.mode[mrm_pkg::B_EME] = !code[2];
         s_d.dbg_en = code == mrm_pkg::MRM_SPC_SC;
         s_d.dbg_act = code == mrm_pkg::MRM_SPC_SC;
      end
      map_hit = reg_addr_in == mrm_pkg::MODE_OFS && !periph;
      if (reg_wr_in && reset_seen_q && map_hit)
      begin
         // Select bit: only while 0, first write dropped
         if (special)
         begin
            if (s_q.first_sel_wr)
               s_d.mode[mrm_pkg::B_SEL] = w[mrm_pkg::B_SEL];
            s_d.first_sel_wr = 1'b1;
         end
         cand = {s_d.mode[mrm_pkg::B_SEL], w[mrm_pkg::B_MHI],
                 w[mrm_pkg::B_MLO]};
         if ((special || !s_q.mode_wr_done) && !is_periph(cand))
         begin
            s_d.mode[mrm_pkg::B_MHI] = w[mrm_pkg::B_MHI];
            s_d.mode[mrm_pkg::B_MLO] = w[mrm_pkg::B_MLO];
         end
         if (!special)
            s_d.mode_wr_done = 1'b1;
         if (!special && !s_q.mode_wr_done)
         begin
            s_d.mode[mrm_pkg::B_E_CLOCK_STRETCH_ENABLE] = w[mrm_pkg::B_E_CLOCK_STRETCH_ENABLE];
            s_d.mode[mrm_pkg::B_INTERNAL_ACCESS_VISIBLE] = w[mrm_pkg::B_INTERNAL_ACCESS_VISIBLE];
            s_d.mode[mrm_pkg::B_EME] = w[mrm_pkg::B_EME];
         end
         if (special && s_q.first_sel_wr)
         begin
            s_d.mode[mrm_pkg::B_E_CLOCK_STRETCH_ENABLE] = w[mrm_pkg::B_E_CLOCK_STRETCH_ENABLE];
            s_d.mode[mrm_pkg::B_INTERNAL_ACCESS_VISIBLE] = w[mrm_pkg::B_INTERNAL_ACCESS_VISIBLE];
            s_d.mode[mrm_pkg::B_EME] = w[mrm_pkg::B_EME];
         end
         if (!special)
            s_d.mode[mrm_pkg::B_EBSW] = w[mrm_pkg::B_EBSW];
         s_d.mode[mrm_pkg::B_ZERO] = 1'b0;
      end
      // Relocation: one write in normal modes, applied a cycle later
      s_d.reloc_pend = 3'h0;
      if (s_q.reloc_pend[0])
         s_d.reg_base = s_q.reg_base_pend;
      if (s_q.reloc_pend[1])
         s_d.ram_base = s_q.ram_base_pend;
      if (s_q.reloc_pend[2])
         s_d.ee_base = s_q.ee_base_pend;
      if (reg_wr_in && reset_seen_q)
      begin
         if (reg_addr_in == mrm_pkg::RELOC_REG_OFS &&
             (special || !s_q.reloc_wr_done[0]))
         begin
            s_d.reg_base_pend = {w[7:3], 11'h000};
            s_d.reloc_pend[0] = 1'b1;
         end
         if (reg_addr_in == mrm_pkg::RELOC_RAM_OFS &&
             (special || !s_q.reloc_wr_done[1]))
         begin
            s_d.ram_base_pend = {w[7:3], 11'h000};
            s_d.reloc_pend[1] = 1'b1;
         end
         if (reg_addr_in == mrm_pkg::RELOC_EE_OFS &&
             (special || !s_q.reloc_wr_done[2]))
         begin
            s_d.ee_base_pend = {w[7:4], 12'h000};
            s_d.reloc_pend[2] = 1'b1;
         end
         if (!special)
            s_d.reloc_wr_done = s_q.reloc_wr_done | {
               reg_addr_in == mrm_pkg::RELOC_EE_OFS,
               reg_addr_in == mrm_pkg::RELOC_RAM_OFS,
               reg_addr_in == mrm_pkg::RELOC_REG_OFS};
      end
      // Debug enable and activation
      if (dbg_enable_cmd_in && reset_seen_q)
         s_d.dbg_en = 1'b1;
      if (s_q.dbg_en && (dbg_serial_act_in || background_enter_instruction_exec_in))
         s_d.dbg_act = 1'b1;
      if (dbg_exit_in && mode_now != mrm_pkg::MRM_SPC_SC)
         s_d.dbg_act = 1'b0;
      // Split external word access in special narrow mode
      case (s_q.bus)
         mrm_pkg::MRM_BUS_IDLE:
         begin
            if (cpu_valid_in && narrow && special &&
                decode(cpu_addr_in, s_q, expanded) == mrm_pkg::MRM_SEL_EXT)
            begin
               s_d.bus = mrm_pkg::MRM_BUS_HIGH;
               s_d.bus_addr = cpu_addr_in;
               s_d.bus_data = cpu_wdata_in;
               s_d.bus_we = cpu_we_in;
            end
         end
         mrm_pkg::MRM_BUS_HIGH:
            s_d.bus = mrm_pkg::MRM_BUS_LOW;
         mrm_pkg::MRM_BUS_LOW:
            s_d.bus = mrm_pkg::MRM_BUS_IDLE;
         default:
            s_d.bus = mrm_pkg::MRM_BUS_IDLE;
      endcase
      // Register read data stand one cycle after the strobe
      s_d.rdata = 8'h00;
      if (reg_rd_in)
      begin
         if (map_hit)
         begin
            s_d.rdata = s_q.mode;
            if (expanded)
               s_d.rdata[mrm_pkg::B_E_CLOCK_STRETCH_ENABLE] = 1'b1;
         end
         else if (reg_addr_in == mrm_pkg::RELOC_REG_OFS)
            s_d.rdata = s_q.reg_base[15:8];
         else if (reg_addr_in == mrm_pkg::RELOC_RAM_OFS)
            s_d.rdata = s_q.ram_base[15:8];
         else if (reg_addr_in == mrm_pkg::RELOC_EE_OFS)
            s_d.rdata = s_q.ee_base[15:8];
         else if (reg_addr_in == mrm_pkg::BDM_STAT_OFS)
            s_d.rdata = {6'h00, s_q.dbg_act, s_q.dbg_en};
      end
      if (!rst_b_in)
      begin
         s_d = '0;
         s_d.mode[mrm_pkg::B_E_CLOCK_STRETCH_ENABLE] = 1'b1;
         s_d.reg_base = mrm_pkg::RELOC_REG_RST;
         s_d.ram_base = mrm_pkg::RELOC_RAM_RST;
         s_d.ee_base = mrm_pkg::RELOC_EE_RST;
         // Keep shifting in reset so the straps are settled at release
         s_d.sync_a = {s_q.sync_a[1:0], dbg_pin_in};
         s_d.sync_b = {s_q.sync_b[1:0], strap_high_in};
         s_d.sync_c = {s_q.sync_c[1:0], strap_low_in};
      end
   end

   always_ff @(posedge clk_in)
   begin
      s_q <= s_d;
      reset_seen_q <= rst_b_in;
   end

   assign strap_live = s_q.sync_a[2] == s_q.sync_a[1];
   assign reg_rdata_out = s_q.rdata;
   assign sel_out = cpu_valid_in ? decode(cpu_addr_in, s_q, expanded)
                                 : mrm_pkg::MRM_SEL_NONE;
   assign ext_busy_out = s_q.bus != mrm_pkg::MRM_BUS_IDLE;
   // Debug steals only idle cycles, never stalls the program
   assign dbg_grant_out = dbg_req_in && cpu_idle_in && !cpu_valid_in &&
                          !periph;
   assign cpu_halt_out = periph || !reset_seen_q;
   assign skip_vector_out = mode_now == mrm_pkg::MRM_SPC_SC;
   assign debug_active_out = s_q.dbg_act;

   always_comb
   begin
      pins_out = '0;
      pins_out.e_pullup = 8'h03;
      pins_out.ab_pullup = 1'b0;
      pins_out.e_bus_ctl = expanded && special &&
                           s_q.mode[mrm_pkg::B_MHI];
      if (s_q.bus == mrm_pkg::MRM_BUS_HIGH)
      begin
         pins_out.a_out = s_q.bus_we ? s_q.bus_data[15:8]
                                     : s_q.bus_addr[15:8];
         pins_out.a_oe = 8'hff;
         pins_out.b_out = s_q.bus_addr[7:0];
         pins_out.b_oe = 8'hff;
      end
      else if (s_q.bus == mrm_pkg::MRM_BUS_LOW)
      begin
         pins_out.a_out = s_q.bus_we ? s_q.bus_data[7:0]
                                     : s_q.bus_addr[15:8];
         pins_out.a_oe = 8'hff;
         pins_out.b_out = s_q.bus_addr[7:0] | 8'h01;
         pins_out.b_oe = 8'hff;
      end
      else if (expanded && cpu_valid_in && strap_live)
      begin
         pins_out.a_out = cpu_we_in ? cpu_wdata_in[15:8]
                                    : cpu_addr_in[15:8];
         pins_out.a_oe = 8'hff;
         pins_out.b_out = (!narrow && cpu_we_in) ? cpu_wdata_in[7:0]
                                                 : cpu_addr_in[7:0];
         pins_out.b_oe = 8'hff;
      end
      // Single-chip modes leave A/B undriven as inputs
   end
endmodule

// ==== verilog/mrm_pkg.sv ====
// Purpose: Constants and carrier types for the mode and resource map block
// Assumes: 16-bit internal address space, 8-bit register port
// Notes: All offsets, fields and relocation reset values live here
package mrm_pkg;
   localparam logic [15:0] MODE_OFS = 16'h000b;
   localparam logic [15:0] RELOC_REG_OFS = 16'h0011;
   localparam logic [15:0] RELOC_RAM_OFS = 16'h0010;
   localparam logic [15:0] RELOC_EE_OFS = 16'h0012;
   localparam logic [15:0] BDM_STAT_OFS = 16'h0014;
   localparam logic [15:0] RELOC_REG_RST = 16'h0000;
   localparam logic [15:0] RELOC_RAM_RST = 16'h0800;
   localparam logic [15:0] RELOC_EE_RST = 16'h0d00;
   localparam logic [15:0] DBG_ROM_LO = 16'hff00;
   localparam logic [15:0] DBG_REG_HI = 16'hff06;
   localparam logic [15:0] REG_SIZE = 16'h0200;
   localparam logic [15:0] RAM_SIZE = 16'h0400;
   localparam logic [15:0] EE_SIZE = 16'h0300;
   localparam logic [15:0] FLASH_LO_SC = 16'h8000;
   localparam int B_SEL = 7;
   localparam int B_MHI = 6;
   localparam int B_MLO = 5;
   localparam int B_E_CLOCK_STRETCH_ENABLE = 4;
   localparam int B_INTERNAL_ACCESS_VISIBLE = 3;
   localparam int B_EBSW = 2;
   localparam int B_ZERO = 1;
   localparam int B_EME = 0;
   localparam int BDM_B_EN = 0;
   localparam int BDM_B_ACT = 1;

   // Strap code {debug pin, strap high, strap low}
   typedef enum logic [2:0] {
      MRM_SPC_SC = 3'h0,
      MRM_SPC_NARROW = 3'h1,
      MRM_PERIPH = 3'h2,
      MRM_SPC_WIDE = 3'h3,
      MRM_NRM_SC = 3'h4,
      MRM_NRM_NARROW = 3'h5,
      MRM_RESERVED = 3'h6,
      MRM_NRM_WIDE = 3'h7
   } mrm_mode_t;

   typedef enum logic [2:0] {
      MRM_SEL_DBG = 3'h0,
      MRM_SEL_REG = 3'h1,
      MRM_SEL_RAM = 3'h3,
      MRM_SEL_EE = 3'h2,
      MRM_SEL_FLASH = 3'h6,
      MRM_SEL_EXT = 3'h7,
      MRM_SEL_NONE = 3'h5
   } mrm_sel_t;

   // Split-cycle sequencer, Gray along idle->high->low
   typedef enum logic [1:0] {
      MRM_BUS_IDLE = 2'h0,
      MRM_BUS_HIGH = 2'h1,
      MRM_BUS_LOW = 2'h3
   } mrm_bus_t;

   typedef struct packed {
      logic [7:0] mode;
      logic first_sel_wr;
      logic mode_wr_done;
      logic [2:0] reloc_wr_done;
      logic [15:0] reg_base;
      logic [15:0] ram_base;
      logic [15:0] ee_base;
      logic [15:0] reg_base_pend;
      logic [15:0] ram_base_pend;
      logic [15:0] ee_base_pend;
      logic [2:0] reloc_pend;
      logic dbg_en;
      logic dbg_act;
      logic [7:0] rdata;
      mrm_bus_t bus;
      logic [15:0] bus_addr;
      logic [15:0] bus_data;
      logic bus_we;
      logic [2:0] sync_a;
      logic [2:0] sync_b;
      logic [2:0] sync_c;
      logic cmd_q;
   } mrm_state_t;

   typedef struct packed {
      logic [7:0] a_out;
      logic [7:0] a_oe;
      logic [7:0] b_out;
      logic [7:0] b_oe;
      logic [7:0] e_pullup;
      logic ab_pullup;
      logic e_bus_ctl;
   } mrm_pins_t;
endpackage
